// [lmc_chk_assertions.sv]
// Concurrent checks on the ports of the mission control block
`timescale 1ns/1ps
`default_nettype none
`include "lmc_defs.svh"
module lmc_chk (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire lmc_pkg::lmc_reg_req_t reg_req,
  input wire logic reg_rvalid,
  input wire logic minute_tick,
  input wire lmc_pkg::lmc_conv_t conv,
  input wire logic log_full,
  input wire logic clear_mem_cmd,
  input wire logic osc_halt,
  input wire logic wrap_enable,
  input wire logic logging_active,
  input wire logic conv_start,
  input wire logic store_sample,
  input wire logic wipe_pulse
);
  import lmc_pkg::*;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  logic wr_low;
  logic wr_ctl;
  assign wr_low = reg_req.wr && reg_req.addr <= `LMC_ADDR_DLY_HI &&
    reg_req.addr >= `LMC_ADDR_FIRST;
  assign wr_ctl = reg_req.wr && reg_req.addr == `LMC_ADDR_CTRL;
  // ======
  // Checks
  rd_answer_a: assert property (reg_req.rd |=> reg_rvalid)
    else $error("read not answered");
  wr_ends_a: assert property (logging_active && wr_low |=> !logging_active)
    else $error("write did not end mission");
  zero_si_a: assert property (!logging_active && reg_req.wr &&
    reg_req.addr == `LMC_ADDR_SI && reg_req.wdata == 8'h00
    |=> !logging_active)
    else $error("zero interval started mission");
  stat_noset_a: assert property (!logging_active && reg_req.wr &&
    reg_req.addr == `LMC_ADDR_STAT |=> !logging_active)
    else $error("status write set active");
  ctrl_upd_a: assert property (!logging_active && wr_ctl |=>
    osc_halt == $past(reg_req.wdata[7]) &&
    wrap_enable == $past(reg_req.wdata[3]))
    else $error("control write lost");
  ctrl_keep_a: assert property (logging_active && wr_ctl |=>
    $stable(osc_halt) && $stable(wrap_enable))
    else $error("control changed by first write");
  conv_pace_a: assert property (conv_start |-> $past(minute_tick, 2))
    else $error("conversion off minute boundary");
  store_cause_a: assert property (store_sample |-> $past(conv.done) &&
    $past(wrap_enable || !log_full))
    else $error("sample stored wrongly");
  wipe_cause_a: assert property (wipe_pulse |-> $past(clear_mem_cmd))
    else $error("wipe without command");
endmodule
bind lmc_mission_ctrl lmc_chk chk_u (.clk_sys, .rst_n, .reg_req,
  .reg_rvalid, .minute_tick, .conv, .log_full, .clear_mem_cmd, .osc_halt,
  .wrap_enable, .logging_active, .conv_start, .store_sample, .wipe_pulse);
`default_nettype wire

// [lmc_defs.svh]
// Offsets, field positions and reset values of the mission control registers
`ifndef LMC_DEFS_SVH
`define LMC_DEFS_SVH

// ==========================================================================
// Register offsets
`define LMC_ADDR_FIRST 10'h200
`define LMC_ADDR_SI 10'h20d
`define LMC_ADDR_CTRL 10'h20e
`define LMC_ADDR_DLY_LO 10'h212
`define LMC_ADDR_DLY_HI 10'h213
`define LMC_ADDR_STAT 10'h214

// ==========================================================================
// Control field positions
`define LMC_CB_OSC_HALT 7
`define LMC_CB_WIPE_ARM 6
`define LMC_CB_UNUSED 5
`define LMC_CB_INHIBIT 4
`define LMC_CB_WRAP 3
`define LMC_CB_LOW_SRCH 2
`define LMC_CB_HIGH_SRCH 1
`define LMC_CB_ALRM_SRCH 0

// ==========================================================================
// Status field positions
`define LMC_SB_CONV_BUSY_N 7
`define LMC_SB_WIPED 6
`define LMC_SB_ACTIVE 5
`define LMC_SB_PENDING 4
`define LMC_SB_UNUSED 3
`define LMC_SB_LOW 2
`define LMC_SB_HIGH 1
`define LMC_SB_ALARM 0

// ==========================================================================
// Reset values
`define LMC_RST_SI 8'h00
`define LMC_RST_CTRL 8'h00
`define LMC_RST_DLY 16'h0000
`define LMC_RST_WIPED 1'b0

`endif

// [lmc_host_model.sv]
// Bus master model that reaches the register page
`timescale 1ns/1ps
`default_nettype none
module lmc_host_model (
  input wire logic clk_sys,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rvalid,
  output var lmc_pkg::lmc_reg_req_t reg_req,
  output logic access_start,
  output logic clear_mem_cmd
);
  import lmc_pkg::*;
  initial begin
    reg_req = '0;
    access_start = 1'b0;
    clear_mem_cmd = 1'b0;
  end
  // Released address and data show the inverse and strobes go low, so stale values never look valid
  task automatic xfer(input logic rd, input logic [9:0] a,
    input logic [7:0] d, output logic [7:0] q);
    int n;
    n = 0;
    @(negedge clk_sys);
    reg_req <= '{rd, ~rd, a, d};
    @(negedge clk_sys);
    reg_req <= '{1'b0, 1'b0, ~a, ~d};
    while (rd && reg_rvalid !== 1'b1 && n < 4) begin
      @(negedge clk_sys);
      n++;
    end
    q = reg_rdata;
  endtask
  // Clear is only honoured as the very next access after arming
  task automatic cmd(input logic clr);
    @(negedge clk_sys);
    if (clr) clear_mem_cmd <= 1'b1;
    else access_start <= 1'b1;
    @(negedge clk_sys);
    clear_mem_cmd <= 1'b0;
    access_start <= 1'b0;
  endtask
endmodule
`default_nettype wire

// [lmc_mission_ctrl.sv]
// Mission control registers and mission sequencing of the logger
`timescale 1ns/1ps
`default_nettype none
`include "lmc_defs.svh"

module lmc_mission_ctrl (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire lmc_pkg::lmc_reg_req_t reg_req,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  input wire logic access_start,
  input wire logic mem_func_cmd,
  input wire logic clear_mem_cmd,
  input wire logic minute_tick,
  input wire logic clock_alarm_evt,
  input wire logic conv_busy,
  input wire lmc_pkg::lmc_conv_t conv,
  input wire logic [7:0] low_threshold,
  input wire logic [7:0] high_threshold,
  input wire logic log_full,
  output logic osc_halt,
  output logic wrap_enable,
  output logic logging_active,
  output logic conv_start,
  output logic store_sample,
  output logic histogram_update,
  output logic wipe_pulse,
  output logic search_match
);
  import lmc_pkg::*;

  // ==========================================================================
  // Decoding
  function automatic logic in_mission_range(input logic [9:0] a);
    in_mission_range = (a >= `LMC_ADDR_FIRST) && (a <= `LMC_ADDR_DLY_HI);
  endfunction

  logic [7:0] si_reg, si_next;
  logic [7:0] ctrl_reg, ctrl_next;
  logic [15:0] dly_reg, dly_next;
  logic wiped_reg, wiped_next;
  logic active_reg, active_next;
  logic pending_reg, pending_next;
  logic low_reg, low_next;
  logic high_reg, high_next;
  logic alarm_reg, alarm_next;
  lmc_arm_t arm_reg, arm_next;
  logic [7:0] rdata_reg, rdata_next;
  logic rvalid_reg, rvalid_next;
  logic conv_start_reg, conv_start_next;
  logic store_reg, store_next;
  logic hist_reg, hist_next;
  logic wipe_reg, wipe_next;
  logic match_reg, match_next;
  logic start_evt, stop_evt, sample_due;
  logic wr, write_blocked, do_wipe;
  logic [7:0] status_word;
  logic [7:0] timer_interval;

  assign wr = reg_req.wr;
  // A write to 200h..213h while logging only ends the mission and is otherwise discarded
  assign write_blocked = wr && active_reg && in_mission_range(reg_req.addr);
  assign do_wipe = clear_mem_cmd && ctrl_reg[`LMC_CB_WIPE_ARM]
                   && (arm_reg == LMC_ARM_NEXT);
  assign start_evt = wr && !active_reg && (reg_req.addr == `LMC_ADDR_SI)
                     && (reg_req.wdata != 8'h00) && wiped_reg
                     && !ctrl_reg[`LMC_CB_INHIBIT];
  // Reloads need the stored interval; only the start cycle sees bus data
  assign timer_interval = start_evt ? reg_req.wdata : si_reg;

  always_comb begin
    status_word = 8'h00;
    status_word[`LMC_SB_CONV_BUSY_N] = !conv_busy;
    status_word[`LMC_SB_WIPED] = wiped_reg;
    status_word[`LMC_SB_ACTIVE] = active_reg;
    status_word[`LMC_SB_PENDING] = pending_reg;
    status_word[`LMC_SB_LOW] = low_reg;
    status_word[`LMC_SB_HIGH] = high_reg;
    status_word[`LMC_SB_ALARM] = alarm_reg;
  end

  // ==========================================================================
  // Configuration registers
  always_comb begin
    si_next = si_reg;
    ctrl_next = ctrl_reg;
    dly_next = dly_reg;
    if (do_wipe) begin
      si_next = `LMC_RST_SI;
      dly_next = `LMC_RST_DLY;
    end else if (wr && !write_blocked) begin
      case (reg_req.addr)
        `LMC_ADDR_SI: si_next = reg_req.wdata;
        `LMC_ADDR_CTRL: begin
          ctrl_next = reg_req.wdata;
          ctrl_next[`LMC_CB_UNUSED] = 1'b0;
        end
        `LMC_ADDR_DLY_LO: dly_next[7:0] = reg_req.wdata;
        `LMC_ADDR_DLY_HI: dly_next[15:8] = reg_req.wdata;
        default: ;
      endcase
    end
    // The arm bit drops when any memory function runs, the clear included
    if (mem_func_cmd || clear_mem_cmd) begin
      ctrl_next[`LMC_CB_WIPE_ARM] = 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      si_reg <= `LMC_RST_SI;
      ctrl_reg <= `LMC_RST_CTRL;
      dly_reg <= `LMC_RST_DLY;
    end else begin
      si_reg <= si_next;
      ctrl_reg <= ctrl_next;
      dly_reg <= dly_next;
    end
  end

  // ==========================================================================
  // Clear-memory arming: the clear must be the access right after arming
  always_comb begin
    arm_next = arm_reg;
    case (arm_reg)
      LMC_ARM_IDLE: begin
        if (wr && !write_blocked && reg_req.addr == `LMC_ADDR_CTRL
            && reg_req.wdata[`LMC_CB_WIPE_ARM]) begin
          arm_next = LMC_ARM_WAIT;
        end
      end
      LMC_ARM_WAIT: begin
        if (access_start) begin
          arm_next = LMC_ARM_NEXT;
        end
      end
      LMC_ARM_NEXT: begin
        // Anything but a clear in this access loses the arming
        if (access_start || mem_func_cmd || clear_mem_cmd) begin
          arm_next = LMC_ARM_IDLE;
        end
      end
      default: arm_next = LMC_ARM_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      arm_reg <= LMC_ARM_IDLE;
    end else begin
      arm_reg <= arm_next;
    end
  end

  // ==========================================================================
  // Mission state and status flags
  always_comb begin
    stop_evt = 1'b0;
    wiped_next = wiped_reg;
    active_next = active_reg;
    pending_next = pending_reg;
    low_next = low_reg;
    high_next = high_reg;
    alarm_next = alarm_reg;
    if (write_blocked) begin
      stop_evt = 1'b1;
    end
    if (wr && reg_req.addr == `LMC_ADDR_STAT) begin
      // Zero clears active, low, high and alarm, one is ignored, so a status write can stop but never start a mission
      if (!reg_req.wdata[`LMC_SB_ACTIVE]) begin
        stop_evt = active_reg;
      end
      if (!reg_req.wdata[`LMC_SB_LOW]) begin
        low_next = 1'b0;
      end
      if (!reg_req.wdata[`LMC_SB_HIGH]) begin
        high_next = 1'b0;
      end
      if (!reg_req.wdata[`LMC_SB_ALARM]) begin
        alarm_next = 1'b0;
      end
    end
    if (stop_evt) begin
      active_next = 1'b0;
      pending_next = 1'b0;
    end
    if (start_evt) begin
      active_next = 1'b1;
      wiped_next = 1'b0;
    end
    if (do_wipe) begin
      wiped_next = 1'b1;
    end
    if (sample_due && active_reg && !stop_evt) begin
      pending_next = 1'b1;
    end
    if (conv.done && pending_reg) begin
      pending_next = 1'b0;
    end
    // Hardware sets win over a clear in the same cycle
    if (conv.done && pending_reg && active_reg) begin
      if (conv.temp <= low_threshold) begin
        low_next = 1'b1;
      end
      if (conv.temp >= high_threshold) begin
        high_next = 1'b1;
      end
    end
    if (clock_alarm_evt) begin
      alarm_next = 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wiped_reg <= `LMC_RST_WIPED;
      active_reg <= 1'b0;
      pending_reg <= 1'b0;
      low_reg <= 1'b0;
      high_reg <= 1'b0;
      alarm_reg <= 1'b0;
    end else begin
      wiped_reg <= wiped_next;
      active_reg <= active_next;
      pending_reg <= pending_next;
      low_reg <= low_next;
      high_reg <= high_next;
      alarm_reg <= alarm_next;
    end
  end

  lmc_mission_timer #(
    .CNT_W(17)
  ) u_timer (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .start(start_evt),
    .stop(stop_evt),
    .minute_tick(minute_tick),
    .start_delay(dly_reg),
    .interval(timer_interval),
    .sample_due(sample_due)
  );

  // ==========================================================================
  // Read port and output strobes
  always_comb begin
    rdata_next = rdata_reg;
    rvalid_next = reg_req.rd;
    if (reg_req.rd) begin
      case (reg_req.addr)
        `LMC_ADDR_SI: rdata_next = si_reg;
        `LMC_ADDR_CTRL: rdata_next = ctrl_reg;
        `LMC_ADDR_DLY_LO: rdata_next = dly_reg[7:0];
        `LMC_ADDR_DLY_HI: rdata_next = dly_reg[15:8];
        `LMC_ADDR_STAT: rdata_next = status_word;
        default: rdata_next = 8'h00;
      endcase
    end
    conv_start_next = sample_due && active_reg && !stop_evt;
    // Full log without wrap keeps measuring but stores nothing
    store_next = conv.done && pending_reg && active_reg
                 && (ctrl_reg[`LMC_CB_WRAP] || !log_full);
    hist_next = conv.done && pending_reg && active_reg;
    wipe_next = do_wipe;
    match_next = (ctrl_reg[`LMC_CB_LOW_SRCH] && low_reg)
                 || (ctrl_reg[`LMC_CB_HIGH_SRCH] && high_reg)
                 || (ctrl_reg[`LMC_CB_ALRM_SRCH] && alarm_reg);
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rdata_reg <= 8'h00;
      rvalid_reg <= 1'b0;
      conv_start_reg <= 1'b0;
      store_reg <= 1'b0;
      hist_reg <= 1'b0;
      wipe_reg <= 1'b0;
      match_reg <= 1'b0;
    end else begin
      rdata_reg <= rdata_next;
      rvalid_reg <= rvalid_next;
      conv_start_reg <= conv_start_next;
      store_reg <= store_next;
      hist_reg <= hist_next;
      wipe_reg <= wipe_next;
      match_reg <= match_next;
    end
  end

  assign reg_rdata = rdata_reg;
  assign reg_rvalid = rvalid_reg;
  assign osc_halt = ctrl_reg[`LMC_CB_OSC_HALT];
  assign wrap_enable = ctrl_reg[`LMC_CB_WRAP];
  assign logging_active = active_reg;
  assign conv_start = conv_start_reg;
  assign store_sample = store_reg;
  assign histogram_update = hist_reg;
  assign wipe_pulse = wipe_reg;
  assign search_match = match_reg;

endmodule
`default_nettype wire

// [lmc_mission_timer.sv]
// Minute countdown that paces the samples of a mission
`timescale 1ns/1ps
`default_nettype none

module lmc_mission_timer #(
  parameter int CNT_W = 17
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic start,
  input wire logic stop,
  input wire logic minute_tick,
  input wire logic [15:0] start_delay,
  input wire logic [7:0] interval,
  output logic sample_due
);
  import lmc_pkg::*;

  logic [CNT_W-1:0] cnt_reg, cnt_next;
  logic run_reg, run_next;
  logic due_reg, due_next;

  always_comb begin
    cnt_next = cnt_reg;
    run_next = run_reg;
    due_next = 1'b0;
    if (stop) begin
      run_next = 1'b0;
    end else if (start) begin
      // First sample lands delay plus one interval after the start
      cnt_next = CNT_W'({1'b0, start_delay}) + CNT_W'(interval);
      run_next = 1'b1;
    end else if (run_reg && minute_tick) begin
      if (cnt_reg <= CNT_W'(1)) begin
        due_next = 1'b1;
        cnt_next = CNT_W'(interval);
      end else begin
        cnt_next = cnt_reg - CNT_W'(1);
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg <= '0;
      run_reg <= 1'b0;
      due_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      run_reg <= run_next;
      due_reg <= due_next;
    end
  end

  assign sample_due = due_reg;

endmodule
`default_nettype wire

// [lmc_pkg.sv]
// Types shared by the mission control block
package lmc_pkg;

  // ==========================================================================
  // Register port request
  typedef struct packed {
    logic rd;
    logic wr;
    logic [9:0] addr;
    logic [7:0] wdata;
  } lmc_reg_req_t;

  // ==========================================================================
  // Finished temperature conversion
  typedef struct packed {
    logic done;
    logic [7:0] temp;
  } lmc_conv_t;

  // Progress of the clear-memory arming sequence
  typedef enum logic [1:0] {
    LMC_ARM_IDLE,
    LMC_ARM_WAIT,
    LMC_ARM_NEXT
  } lmc_arm_t;

endpackage

// [tb_top.sv]
// Self-checking bench of the mission control registers
`timescale 1ns/1ps
`default_nettype none
`include "lmc_defs.svh"
module tb_top;
  import lmc_pkg::*;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic minute_tick = 1'b0;
  logic log_full = 1'b0;
  logic mem_func_cmd = 1'b0;
  logic clock_alarm_evt = 1'b0;
  logic conv_busy = 1'b0;
  lmc_conv_t conv = '0;
  lmc_reg_req_t reg_req;
  logic access_start, clear_mem_cmd, reg_rvalid;
  logic [7:0] reg_rdata, q;
  logic osc_halt, wrap_enable, logging_active, conv_start;
  logic store_sample, histogram_update, wipe_pulse, search_match;
  int n_fail = 0;
  int tests_run = 0;
  int cyc = 0;
  always #2 clk_sys = ~clk_sys;
  lmc_host_model host_u (.clk_sys, .reg_rdata, .reg_rvalid, .reg_req,
    .access_start, .clear_mem_cmd);
  lmc_mission_ctrl dut_u (.clk_sys, .rst_n, .reg_req, .reg_rdata,
    .reg_rvalid, .access_start, .mem_func_cmd, .clear_mem_cmd,
    .minute_tick, .clock_alarm_evt, .conv_busy, .conv,
    .low_threshold(8'h10), .high_threshold(8'hf0), .log_full, .osc_halt,
    .wrap_enable, .logging_active, .conv_start, .store_sample,
    .histogram_update, .wipe_pulse, .search_match);
  // ======
  // Tasks
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    tests_run++;
    if (g !== e) begin
      n_fail++;
      $display("unexpected at %0t: got %h exp %h", $time, g, e);
    end
  endtask
  task automatic rd_chk(input logic [9:0] a, input logic [7:0] e);
    host_u.xfer(1'b1, a, 8'h00, q);
    chk(16'(q), 16'(e));
  endtask
  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    host_u.xfer(1'b0, a, d, q);
  endtask
  // Counts conversion starts in the three cycles after one minute pulse
  task automatic tick(input logic [1:0] e);
    int c;
    c = 0;
    @(negedge clk_sys);
    minute_tick <= 1'b1;
    @(negedge clk_sys);
    minute_tick <= 1'b0;
    repeat (3) begin
      if (conv_start === 1'b1) c++;
      @(negedge clk_sys);
    end
    chk(16'(c), 16'(e));
  endtask
  task automatic samp(input logic [7:0] t, input logic [1:0] e);
    @(negedge clk_sys);
    conv <= '{1'b1, t};
    @(negedge clk_sys);
    conv <= '{1'b0, ~t};
    chk(16'({store_sample, histogram_update}), 16'(e));
  endtask
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 3000) begin
      n_fail++;
      final_report();
    end
  end
  // ======
  // Sequence
  initial begin
    repeat (12) @(negedge clk_sys);
    rst_n <= 1'b1;
    rd_chk(`LMC_ADDR_SI, 8'h00);
    rd_chk(`LMC_ADDR_STAT, 8'h80);
    conv_busy <= 1'b1;
    rd_chk(`LMC_ADDR_STAT, 8'h00);
    conv_busy <= 1'b0;
    rd_chk(10'h20f, 8'h00);
    wr(`LMC_ADDR_CTRL, 8'hff);
    rd_chk(`LMC_ADDR_CTRL, 8'hdf);
    chk(16'({osc_halt, wrap_enable}), 16'h3);
    wr(`LMC_ADDR_STAT, 8'hff);
    wr(`LMC_ADDR_SI, 8'h05);
    rd_chk(`LMC_ADDR_STAT, 8'h80);
    wr(`LMC_ADDR_CTRL, 8'h40);
    host_u.cmd(1'b0);
    host_u.cmd(1'b1);
    chk(16'(wipe_pulse), 16'h1);
    rd_chk(`LMC_ADDR_SI, 8'h00);
    rd_chk(`LMC_ADDR_CTRL, 8'h00);
    rd_chk(`LMC_ADDR_STAT, 8'hc0);
    wr(`LMC_ADDR_SI, 8'h00);
    chk(16'(logging_active), 16'h0);
    wr(`LMC_ADDR_DLY_LO, 8'h01);
    wr(`LMC_ADDR_CTRL, 8'h04);
    wr(`LMC_ADDR_SI, 8'h02);
    rd_chk(`LMC_ADDR_STAT, 8'ha0);
    tick(2'd0);
    tick(2'd0);
    tick(2'd1);
    samp(8'h08, 2'b11);
    // Match is registered from the flag, one cycle after the trip
    @(negedge clk_sys);
    chk(16'(search_match), 16'h1);
    log_full <= 1'b1;
    tick(2'd0);
    tick(2'd1);
    samp(8'hf5, 2'b01);
    rd_chk(`LMC_ADDR_STAT, 8'ha6);
    wr(`LMC_ADDR_CTRL, 8'h0f);
    rd_chk(`LMC_ADDR_CTRL, 8'h04);
    chk(16'(logging_active), 16'h0);
    wr(`LMC_ADDR_CTRL, 8'h0c);
    rd_chk(`LMC_ADDR_CTRL, 8'h0c);
    wr(`LMC_ADDR_CTRL, 8'h41);
    @(negedge clk_sys);
    mem_func_cmd <= 1'b1;
    @(negedge clk_sys);
    mem_func_cmd <= 1'b0;
    rd_chk(`LMC_ADDR_CTRL, 8'h01);
    host_u.cmd(1'b1);
    chk(16'(wipe_pulse), 16'h0);
    chk(16'(search_match), 16'h0);
    @(negedge clk_sys);
    clock_alarm_evt <= 1'b1;
    @(negedge clk_sys);
    clock_alarm_evt <= 1'b0;
    rd_chk(`LMC_ADDR_STAT, 8'h87);
    chk(16'(search_match), 16'h1);
    wr(`LMC_ADDR_STAT, 8'h00);
    rd_chk(`LMC_ADDR_STAT, 8'h80);
    final_report();
  end
endmodule
`default_nettype wire
